// [usb_bulkin_intep_cfg.svh]
// register offsets, reset values, field positions and timing figures
// assumes a 50 MHz aclk and a 12-bit AXI4-Lite byte address
`ifndef USB_BULKIN_INTEP_CFG_SVH
`define USB_BULKIN_INTEP_CFG_SVH

`define ADDR_W              12
`define OFS_STATUS          12'h07c
`define OFS_CFG0            12'h080
`define OFS_CFG1            12'h084
`define OFS_DETACH          12'h088
`define OFS_BURST           12'h090
`define OFS_DELAY           12'h094
`define OFS_INTEP           12'h098

`define MASK_CFG0           32'h00000020
`define MASK_CFG1           32'h0000e073
`define MASK_DETACH         32'hffffffff
`define MASK_BURST          32'h000000ff
`define MASK_DELAY          32'h0000ffff
`define MASK_INTEP          32'h97f80000
`define INTEP_EVENT_MASK    32'h17f80000

`define RST_DELAY           32'h00000800
`define RST_SS_DETACH       16'h001e
`define RST_HIGHSPEED_DETACH_MS       16'h000a
`define RST_TRIM            3'h0

`define BIT_BCE             5
`define BIT_ALWAYS          31
`define HS_TRIM_RANGE       15:13
`define FS_TRIM_RANGE       6:4
`define SCALE_RANGE         1:0
`define SS_DETACH_RANGE     31:16
`define HIGHSPEED_DETACH_MS_RANGE     15:0

// 17 bit times in fifths; a 60 MHz phy clock adds 0.2 bit time per trim step
`define FS_BASE_FIFTHS      8'h55
`define FS_FIFTHS_PER_TRIM  8'h01

`define SHIFT_SS            5'h0a
`define SHIFT_HS            5'h09
`define SHIFT_FS            5'h06
`define BURST_MIN_BYTES     19'h00800

`define SS_TXEQ_REAL        20'h10000
`define SS_TXEQ_SCALED      20'h00008
`define SS_LFPS_NS_REAL     20'h003e8
`define SS_LFPS_NS_SCALED   20'h00064
`define SS_WARM_US_REAL     20'h13880
`define SS_WARM_US_SCALED   20'h0001e

`define MS_NS               32'h000f4240
`define CLK_NS              32'h00000014
`define CLK_PS              32'h00004e20
`define DLY_UNIT_PS         32'h0000411b

`endif

// [usb_bulkin_intep_pkg.sv]
// types shared by the configuration block and its users
package usb_bulkin_intep_pkg;
  typedef enum logic [1:0] {speed_ss = 2'b00, speed_hs = 2'b01, speed_fs = 2'b10} speed_type;
  typedef struct packed {
    logic [2:0]  fs_trim_image_field;
    logic [2:0]  hs_trim_image_field;
    logic [15:0] ss_detach_ms;
    logic [15:0] highspeed_detach_ms;
  } image_type;
  typedef enum logic [1:0] {det_attached = 2'b00, det_counting = 2'b01} detach_state_type;
  typedef enum logic [1:0] {dly_idle = 2'b00, dly_wait = 2'b01, dly_go = 2'b11} dly_state_type;
  typedef enum logic [2:0] {
    sel_none, sel_status, sel_cfg0, sel_cfg1, sel_detach, sel_burst, sel_delay, sel_intep
  } reg_sel_type;
endpackage

// [usb_bulkin_intep_config.sv]
// usb device-side configuration: timeout trims, scale-down, detach timer,
// bulk-in burst limit, short-packet delay and interrupt endpoint gating
// assumes one 50 MHz clock, synchronous inputs, an AXI4-Lite master
//
// Overview of operation
// - fs timeout adds trim times bit factor
// - base fs timeout within 16 to 18
// - hs trim presented when not full speed
// - trim factor assumes 60 MHz phy clock
// - scale-down selector: off, timing, suspend, both
// - superspeed scaled training, lfps and warm reset
// - superspeed soft reset detaches for upper field
// - high/full speed detaches for lower field
// - superspeed detach defaults to 0x1e ms
// - high/full detach defaults to 0x0a ms
// - usb or lite reset reloads image trims
// - burst limit reached ends burst with zlp
// - burst units 1024, 512, 64 bytes
// - limit ignored at 2048 bytes or less
// - limit active only with enable bit set
// - short packet waits programmed 16.667 ns units
// - always-send bit returns packet every interval
// - event enables reset zero, gate packets
// - bits 26..24 enable eee events
// - bits 23..19 enable mac and usb events
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "usb_bulkin_intep_cfg.svh"
module usb_bulkin_intep_config
  import usb_bulkin_intep_pkg::*;
#(
  parameter logic [15:0] CYCLES_PER_MS = 16'(`MS_NS / `CLK_NS)
) (
  input  logic                aclk,
  input  logic                aresetn,
  input  logic [`ADDR_W-1:0]  awaddr,
  input  logic                awvalid,
  output logic                awready,
  input  logic [31:0]         wdata,
  input  logic [3:0]          wstrb,
  input  logic                wvalid,
  output logic                wready,
  output logic [1:0]          bresp,
  output logic                bvalid,
  input  logic                bready,
  input  logic [`ADDR_W-1:0]  araddr,
  input  logic                arvalid,
  output logic                arready,
  output logic [31:0]         rdata,
  output logic [1:0]          rresp,
  output logic                rvalid,
  input  logic                rready,
  input  speed_type           link_speed,
  input  logic                usb_bus_reset,
  input  logic                lite_soft_reset,
  input  logic                image_load,
  input  image_type           image_data,
  input  logic                soft_reset_req,
  output logic                bus_detached,
  output logic [2:0]          core_timeout_trim,
  output logic [7:0]          fs_timeout_fifths,
  output logic                scale_timing,
  output logic                scale_suspend,
  output logic [19:0]         ss_txeq_sequences,
  output logic [19:0]         ss_lfps_burst_ns,
  output logic [19:0]         ss_warm_reset_us,
  input  logic                tx_pkt_done,
  input  logic [10:0]         tx_pkt_bytes,
  output logic                burst_end_zlp,
  input  logic                short_pending,
  output logic                short_release,
  input  logic [31:0]         ep_events,
  input  logic                int_interval_tick,
  output logic                int_packet_send,
  output logic [31:0]         int_packet_status
);

  localparam logic [31:0] EVT_MASK = `INTEP_EVENT_MASK;

  logic [31:0]      cfg0_reg, cfg1_reg, detach_reg, burst_reg, delay_reg, intep_reg;
  logic [31:0]      pending;
  image_type        image_reg;
  logic             image_present_reg;
  logic [`ADDR_W-1:0] aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             aw_full_reg, w_full_reg;
  logic             wr_fire;
  logic             reload;
  detach_state_type det_state_reg;
  logic [15:0]      ms_left_reg, cyc_left_reg;
  dly_state_type    dly_state_reg;
  logic [31:0]      dly_acc_reg, dly_target_reg;
  logic [18:0]      burst_acc_reg, burst_limit, burst_sum;
  logic             burst_active;
  logic [31:0]      evt_hit;
  logic             int_fire;

  function automatic reg_sel_type decode(input logic [`ADDR_W-1:0] a);
    logic [`ADDR_W-1:0] w;
    w = {a[`ADDR_W-1:2], 2'b00};
    case (w)
      `OFS_STATUS: decode = sel_status;
      `OFS_CFG0:   decode = sel_cfg0;
      `OFS_CFG1:   decode = sel_cfg1;
      `OFS_DETACH: decode = sel_detach;
      `OFS_BURST:  decode = sel_burst;
      `OFS_DELAY:  decode = sel_delay;
      `OFS_INTEP:  decode = sel_intep;
      default:     decode = sel_none;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [31:0] m);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    merge = r & m;
  endfunction

  function automatic logic [4:0] unit_shift(input speed_type sp);
    case (sp)
      speed_ss: unit_shift = `SHIFT_SS;
      speed_hs: unit_shift = `SHIFT_HS;
      default:  unit_shift = `SHIFT_FS;
    endcase
  endfunction

  // ---------------- AXI4-Lite write channel ----------------
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready     <= 1'b0;
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (awvalid && awready) begin
      awready     <= 1'b0;
      aw_full_reg <= 1'b1;
      aw_addr_reg <= awaddr;
    end else begin
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
      end
      awready <= !aw_full_reg && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready     <= 1'b0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (wvalid && wready) begin
      wready     <= 1'b0;
      w_full_reg <= 1'b1;
      w_data_reg <= wdata;
      w_strb_reg <= wstrb;
    end else begin
      if (wr_fire) begin
        w_full_reg <= 1'b0;
      end
      wready <= !w_full_reg && !bvalid;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= 2'b00;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (decode(aw_addr_reg) inside {sel_none, sel_status}) ? 2'b10 : 2'b00;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // ---------------- AXI4-Lite read channel ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= 2'b00;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= (decode(araddr) == sel_none) ? 2'b10 : 2'b00;
      case (decode(araddr))
        sel_status: rdata <= pending | {30'h0, dly_state_reg != dly_idle, bus_detached};
        sel_cfg0:   rdata <= cfg0_reg;
        sel_cfg1:   rdata <= cfg1_reg;
        sel_detach: rdata <= detach_reg;
        sel_burst:  rdata <= burst_reg;
        sel_delay:  rdata <= delay_reg;
        sel_intep:  rdata <= intep_reg;
        default:    rdata <= 32'h00000000;
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else begin
      arready <= !rvalid;
    end
  end

  // ---------------- register file ----------------
  assign reload = usb_bus_reset || lite_soft_reset;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      image_reg         <= '0;
      image_present_reg <= 1'b0;
    end else if (image_load) begin
      image_reg         <= image_data;
      image_present_reg <= 1'b1;
    end
  end

  // trims and detach times follow the image, or defaults when none was loaded
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg1_reg   <= '0;
      detach_reg <= {`RST_SS_DETACH, `RST_HIGHSPEED_DETACH_MS};
    end else if (image_load) begin
      cfg1_reg[`HS_TRIM_RANGE]     <= image_data.hs_trim_image_field;
      cfg1_reg[`FS_TRIM_RANGE]     <= image_data.fs_trim_image_field;
      detach_reg                   <= {image_data.ss_detach_ms, image_data.highspeed_detach_ms};
    end else if (reload) begin
      cfg1_reg[`HS_TRIM_RANGE] <= image_present_reg ? image_reg.hs_trim_image_field
                                                    : `RST_TRIM;
      cfg1_reg[`FS_TRIM_RANGE] <= image_present_reg ? image_reg.fs_trim_image_field
                                                    : `RST_TRIM;
      detach_reg <= image_present_reg ? {image_reg.ss_detach_ms, image_reg.highspeed_detach_ms}
                                      : {`RST_SS_DETACH, `RST_HIGHSPEED_DETACH_MS};
    end else if (wr_fire && decode(aw_addr_reg) == sel_cfg1) begin
      cfg1_reg <= merge(cfg1_reg, w_data_reg, w_strb_reg, `MASK_CFG1);
    end else if (wr_fire && decode(aw_addr_reg) == sel_detach) begin
      detach_reg <= merge(detach_reg, w_data_reg, w_strb_reg, `MASK_DETACH);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg0_reg  <= '0;
      burst_reg <= '0;
      delay_reg <= `RST_DELAY;
      intep_reg <= '0;
    end else if (wr_fire) begin
      case (decode(aw_addr_reg))
        sel_cfg0:  cfg0_reg  <= merge(cfg0_reg, w_data_reg, w_strb_reg, `MASK_CFG0);
        sel_burst: burst_reg <= merge(burst_reg, w_data_reg, w_strb_reg, `MASK_BURST);
        sel_delay: delay_reg <= merge(delay_reg, w_data_reg, w_strb_reg, `MASK_DELAY);
        sel_intep: intep_reg <= merge(intep_reg, w_data_reg, w_strb_reg, `MASK_INTEP);
        default:   cfg0_reg  <= cfg0_reg;
      endcase
    end
  end

  // ---------------- timing configuration to the core ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_timeout_trim <= '0;
      fs_timeout_fifths <= `FS_BASE_FIFTHS;
      scale_timing      <= 1'b0;
      scale_suspend     <= 1'b0;
      ss_txeq_sequences <= `SS_TXEQ_REAL;
      ss_lfps_burst_ns  <= `SS_LFPS_NS_REAL;
      ss_warm_reset_us  <= `SS_WARM_US_REAL;
    end else begin
      core_timeout_trim <= (link_speed == speed_fs) ? cfg1_reg[`FS_TRIM_RANGE]
                                                    : cfg1_reg[`HS_TRIM_RANGE];
      fs_timeout_fifths <= `FS_BASE_FIFTHS
                           + 8'(cfg1_reg[`FS_TRIM_RANGE]) * `FS_FIFTHS_PER_TRIM;
      scale_timing      <= cfg1_reg[0];
      scale_suspend     <= cfg1_reg[1];
      ss_txeq_sequences <= cfg1_reg[1] ? 20'h00000
                         : (cfg1_reg[0] ? `SS_TXEQ_SCALED : `SS_TXEQ_REAL);
      ss_lfps_burst_ns  <= cfg1_reg[0] ? `SS_LFPS_NS_SCALED : `SS_LFPS_NS_REAL;
      ss_warm_reset_us  <= cfg1_reg[0] ? `SS_WARM_US_SCALED : `SS_WARM_US_REAL;
    end
  end

  // ---------------- soft reset detach timer ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      det_state_reg <= det_attached;
      bus_detached  <= 1'b0;
      ms_left_reg   <= '0;
      cyc_left_reg  <= '0;
    end else begin
      case (det_state_reg)
        det_attached: begin
          ms_left_reg  <= (link_speed == speed_ss) ? detach_reg[`SS_DETACH_RANGE]
                                                   : detach_reg[`HIGHSPEED_DETACH_MS_RANGE];
          cyc_left_reg <= CYCLES_PER_MS - 16'h0001;
          if (soft_reset_req && ((link_speed == speed_ss) ? |detach_reg[`SS_DETACH_RANGE]
                                                          : |detach_reg[`HIGHSPEED_DETACH_MS_RANGE])) begin
            det_state_reg <= det_counting;
            bus_detached  <= 1'b1;
          end
        end
        det_counting: begin
          if (cyc_left_reg != 16'h0000) begin
            cyc_left_reg <= cyc_left_reg - 16'h0001;
          end else if (ms_left_reg == 16'h0001) begin
            det_state_reg <= det_attached;
            bus_detached  <= 1'b0;
          end else begin
            ms_left_reg  <= ms_left_reg - 16'h0001;
            cyc_left_reg <= CYCLES_PER_MS - 16'h0001;
          end
        end
        default: det_state_reg <= det_attached;
      endcase
    end
  end

  // ---------------- bulk-in burst limit ----------------
  assign burst_limit  = 19'(burst_reg[7:0]) << unit_shift(link_speed);
  assign burst_active = cfg0_reg[`BIT_BCE] && (burst_limit > `BURST_MIN_BYTES);
  assign burst_sum    = burst_acc_reg + 19'(tx_pkt_bytes);

  // a short packet closes the burst on its own, so the count restarts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_acc_reg <= '0;
      burst_end_zlp <= 1'b0;
    end else begin
      burst_end_zlp <= 1'b0;
      if (!burst_active) begin
        burst_acc_reg <= '0;
      end else if (tx_pkt_done) begin
        if (tx_pkt_bytes < (11'h001 << unit_shift(link_speed))) begin
          burst_acc_reg <= '0;
        end else if (burst_sum >= burst_limit) begin
          burst_acc_reg <= '0;
          burst_end_zlp <= 1'b1;
        end else begin
          burst_acc_reg <= burst_sum;
        end
      end
    end
  end

  // ---------------- short packet delay ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_state_reg  <= dly_idle;
      dly_acc_reg    <= '0;
      dly_target_reg <= '0;
      short_release  <= 1'b0;
    end else begin
      short_release <= 1'b0;
      case (dly_state_reg)
        dly_idle: begin
          dly_acc_reg    <= `CLK_PS;
          dly_target_reg <= 32'(delay_reg[15:0]) * `DLY_UNIT_PS;
          if (short_pending) begin
            dly_state_reg <= dly_wait;
          end
        end
        dly_wait: begin
          if (dly_acc_reg >= dly_target_reg) begin
            dly_state_reg <= dly_go;
            short_release <= 1'b1;
          end else begin
            dly_acc_reg <= dly_acc_reg + `CLK_PS;
          end
        end
        dly_go: begin
          if (!short_pending) begin
            dly_state_reg <= dly_idle;
          end
        end
        default: dly_state_reg <= dly_idle;
      endcase
    end
  end

  // ---------------- interrupt endpoint ----------------
  assign evt_hit  = ep_events & intep_reg & EVT_MASK;
  assign int_fire = int_interval_tick && (intep_reg[`BIT_ALWAYS] || |(pending | evt_hit));

  genvar gi;
  for (gi = 0; gi < 32; gi++) begin : g_evt
    if (EVT_MASK[gi]) begin : g_live
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pending[gi] <= 1'b0;
        end else if (evt_hit[gi]) begin
          pending[gi] <= 1'b1;
        end else if (int_fire) begin
          pending[gi] <= 1'b0;
        end
      end
    end else begin : g_rsvd
      assign pending[gi] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_packet_send   <= 1'b0;
      int_packet_status <= '0;
    end else begin
      int_packet_send <= int_fire;
      if (int_fire) begin
        int_packet_status <= pending | evt_hit;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trim_select: assert property ((link_speed != speed_fs) |=>
      core_timeout_trim == $past(cfg1_reg[`HS_TRIM_RANGE]))
    else $error("hs trim not presented outside full speed");
  a_fs_timeout_span: assert property (##1 (fs_timeout_fifths >= 8'h50 &&
      fs_timeout_fifths <= 8'h5a + 8'h07))
    else $error("fs timeout outside base range plus trim");
  a_detach_start: assert property ((soft_reset_req && !bus_detached && link_speed == speed_ss &&
      detach_reg[`SS_DETACH_RANGE] != 16'h0000) |=> bus_detached ##1 bus_detached)
    else $error("ss soft reset did not detach");
  a_detach_end: assert property ($fell(bus_detached) |-> $past(ms_left_reg) == 16'h0001 &&
      $past(cyc_left_reg) == 16'h0000)
    else $error("detach ended early");
  a_reload_defaults: assert property ((usb_bus_reset && !image_load && !image_present_reg) |=>
      detach_reg == {`RST_SS_DETACH, `RST_HIGHSPEED_DETACH_MS} && cfg1_reg[`HS_TRIM_RANGE] == `RST_TRIM &&
      cfg1_reg[`FS_TRIM_RANGE] == `RST_TRIM)
    else $error("reload without image missed defaults");
  a_zlp_gated: assert property (burst_end_zlp |-> $past(cfg0_reg[`BIT_BCE]) &&
      $past(burst_limit) > `BURST_MIN_BYTES)
    else $error("zlp issued while burst limit inactive");
  a_delay_wait: assert property ($rose(short_release) |-> $past(dly_state_reg) == dly_wait &&
      $past(dly_acc_reg) >= $past(dly_target_reg))
    else $error("short packet released before delay");
  a_intep_quiet: assert property ((int_interval_tick && !intep_reg[31] && pending == 32'h0 &&
      evt_hit == 32'h0) |=> !int_packet_send)
    else $error("interrupt packet with no enabled event");
  a_intep_always: assert property ((int_interval_tick && intep_reg[31]) |=> int_packet_send)
    else $error("always-send interval produced no packet");
  a_reserved_zero: assert property (##1 (intep_reg & ~`MASK_INTEP) == 32'h0 &&
      (cfg1_reg & ~`MASK_CFG1) == 32'h0)
    else $error("reserved bits became set");

  c_detach_cycle: cover property ($rose(bus_detached) ##[1:1000] $fell(bus_detached));
  c_burst_zlp:    cover property (burst_end_zlp);
  c_short_delay:  cover property ($rose(short_pending) ##[1:1000] short_release);
  c_event_packet: cover property (int_packet_send && int_packet_status != 32'h0);

endmodule

// [usb_host_partner.sv]
// partner: bulk-in transmitter side holding a short packet until released
// assumes go_short is driven just after a rising edge of aclk
`timescale 1ns/100ps
module usb_host_partner (
  input  wire logic        aclk,
  input  wire logic        go_short,
  input  wire logic        short_release,
  output logic             short_pending,
  output logic [31:0]      wait_cycles
);
  initial short_pending = 1'h0;
  initial wait_cycles = '0;
  // the packet is dropped only at the edge that sees the release
  always @(posedge aclk) begin
    if (!short_pending && go_short) begin
      short_pending <= 1'h1;
      wait_cycles <= '0;
    end else if (short_pending) begin
      wait_cycles <= wait_cycles + 32'h1;
      if (short_release) short_pending <= 1'h0;
    end
  end
endmodule

// [usb_bulkin_intep_config_test.sv]
// bench: register bus, packet and event stimulus, inline expected values compared at every result
// assumes package, header, design and partner model are compiled first
`timescale 1ns/100ps
module usb_bulkin_intep_config_test import usb_bulkin_intep_pkg::*; ;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, usb_bus_reset = 1'h0, lite_soft_reset = 1'h0;
  logic        image_load = 1'h0, soft_reset_req = 1'h0, tx_pkt_done = 1'h0, go_short = 1'h0;
  logic        int_interval_tick = 1'h0, awready, wready, bvalid, arready, rvalid;
  logic        bus_detached, scale_timing, scale_suspend, burst_end_zlp, short_pending;
  logic        short_release, int_packet_send;
  logic [1:0]  bresp, rresp, rr;
  logic [2:0]  core_timeout_trim;
  logic [3:0]  wstrb = 4'hf;
  logic [7:0]  fs_timeout_fifths;
  logic [10:0] tx_pkt_bytes = '0;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [19:0] ss_txeq_sequences, ss_lfps_burst_ns, ss_warm_reset_us;
  logic [31:0] wdata = '0, rdata, ep_events = '0, int_packet_status, wait_cycles, rv, ev, st;
  speed_type   link_speed = speed_hs;
  image_type   image_data = '{3'h2, 3'h6, 16'h0003, 16'h0001};
  integer      seed = 32'h567ff5c9;
  int          failures = 0, n_compared = 0, sends = 0, zlps = 0, n, e, u;
  speed_type   sp[5] = '{speed_ss, speed_hs, speed_fs, speed_hs, speed_hs};
  int          lim[5] = '{5, 5, 32, 4, 5}, en[5] = '{1, 1, 1, 1, 0}, dl[3] = '{1, 3, 2048};
  int          bits[9] = '{28, 26, 25, 24, 23, 22, 21, 20, 19};

  always #10 aclk = ~aclk;
  always @(posedge aclk) begin
    zlps <= zlps + (burst_end_zlp === 1'h1);
    if (int_packet_send === 1'h1) begin
      sends <= sends + 1;
      st <= int_packet_status;
    end
  end

  usb_bulkin_intep_config #(.CYCLES_PER_MS(16'h000a)) uut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .link_speed, .usb_bus_reset, .lite_soft_reset, .image_load, .image_data,
    .soft_reset_req, .bus_detached, .core_timeout_trim, .fs_timeout_fifths,
    .scale_timing, .scale_suspend, .ss_txeq_sequences, .ss_lfps_burst_ns,
    .ss_warm_reset_us, .tx_pkt_done, .tx_pkt_bytes, .burst_end_zlp, .short_pending,
    .short_release, .ep_events, .int_interval_tick, .int_packet_send, .int_packet_status);
  usb_host_partner partner (.aclk, .go_short, .short_release, .short_pending, .wait_cycles);

  task results;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_compared++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task step(input int c);
    repeat (c) @(posedge aclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && t < 50);
    bready <= 1'h0;
    chk("bresp", 32'h0, {30'h0, bresp});
    if (t >= 50) failures++;
  endtask
  task rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    t = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      t++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && t < 50);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (t >= 50) failures++;
  endtask
  task rc(input logic [11:0] a, input logic [31:0] x);
    rd(a, rv, rr);
    chk("rdata", x, rv);
  endtask
  task fire(input logic [31:0] evv, input logic tk);
    @(posedge aclk);
    ep_events <= evv;
    int_interval_tick <= tk;
    @(posedge aclk);
    ep_events <= '0;
    int_interval_tick <= 1'h0;
    step(3);
  endtask

  initial begin
    #400000;
    failures++;
    results;
  end

  initial begin
    step(4);
    aresetn <= 1'h1;
    rc(12'h088, 32'h001e000a);
    rc(12'h094, 32'h00000800);
    rc(12'h098, '0);
    rd(12'h0fc, rv, rr);
    chk("rresp", 32'h2, {30'h0, rr});
    ev = $random(seed);
    wr(12'h098, ev);
    rc(12'h098, ev & 32'h97f80000);
    wr(12'h090, ev);
    rc(12'h090, ev & 32'h000000ff);
    wstrb <= 4'h2;
    wr(12'h088, 32'h12345678);
    wstrb <= 4'hf;
    rc(12'h088, 32'h001e560a);
    for (int s = 0; s < 4; s++) begin
      wr(12'h084, 32'h00006050 | s);
      link_speed <= s[0] ? speed_fs : speed_hs;
      step(3);
      chk("trim", s[0] ? 5 : 3, core_timeout_trim);
      chk("fs_to", 85 + 5, fs_timeout_fifths);
      chk("scale", s, {scale_suspend, scale_timing});
      chk("txeq", s[1] ? 0 : s[0] ? 8 : 32'h10000, ss_txeq_sequences);
      chk("lfps", s[0] ? 100 : 1000, ss_lfps_burst_ns);
      chk("warm", s[0] ? 30 : 80000, ss_warm_reset_us);
    end
    link_speed <= speed_hs;
    for (int i = 0; i < 3; i++) begin
      @(posedge aclk);
      image_load <= (i == 2);
      @(posedge aclk);
      image_load <= 1'h0;
      wr(12'h084, 32'h00006050);
      wr(12'h088, 32'h00050002);
      @(posedge aclk);
      usb_bus_reset <= (i != 1);
      lite_soft_reset <= (i == 1);
      @(posedge aclk);
      usb_bus_reset <= 1'h0;
      lite_soft_reset <= 1'h0;
      step(3);
      chk("trim", i == 2 ? 6 : 0, core_timeout_trim);
      rc(12'h088, i == 2 ? 32'h00030001 : 32'h001e000a);
    end
    for (int i = 0; i < 2; i++) begin
      link_speed <= i ? speed_hs : speed_ss;
      @(posedge aclk);
      soft_reset_req <= 1'h1;
      @(posedge aclk);
      soft_reset_req <= 1'h0;
      n = 0;
      @(posedge aclk);
      while (bus_detached === 1'h1 && n < 100) begin
        @(posedge aclk);
        n++;
      end
      e = i ? 10 : 30;
      chk("detach", 1, n >= e && n <= e + 3);
    end
    for (int k = 0; k < 5; k++) begin
      wr(12'h080, en[k] << 5);
      wr(12'h090, lim[k]);
      link_speed <= sp[k];
      u = (sp[k] == speed_ss) ? 1024 : (sp[k] == speed_hs) ? 512 : 64;
      n = zlps;
      for (int p = 0; p < 7; p++) begin
        @(posedge aclk);
        tx_pkt_done <= 1'h1;
        tx_pkt_bytes <= p ? 11'(u) : 11'h001;
        @(posedge aclk);
        tx_pkt_done <= 1'h0;
        step(1);
      end
      step(2);
      e = (en[k] && lim[k] * u > 2048) ? 6 / lim[k] : 0;
      chk("zlp", e, zlps - n);
    end
    for (int k = 0; k < 3; k++) begin
      wr(12'h094, dl[k]);
      @(posedge aclk);
      go_short <= 1'h1;
      @(posedge aclk);
      go_short <= 1'h0;
      n = 0;
      step(1);
      while (short_pending === 1'h1 && n < 2000) begin
        @(posedge aclk);
        n++;
      end
      e = (dl[k] * 16667 + 19999) / 20000 + 1;
      if (e < 2) e = 2;
      chk("delay", 1, wait_cycles >= e && wait_cycles <= e + 2);
    end
    for (int k = 0; k < 9; k++) begin
      ev = $random(seed) & ~(32'h1 << bits[k]);
      wr(12'h098, 32'h1 << bits[k]);
      n = sends;
      fire(ev, 1'h0);
      fire('0, 1'h1);
      chk("quiet", n, sends);
      fire(ev | (32'h1 << bits[k]), 1'h0);
      rc(12'h07c, 32'h1 << bits[k]);
      fire('0, 1'h1);
      chk("sends", n + 1, sends);
      chk("status", 32'h1 << bits[k], st);
    end
    wr(12'h098, 32'h80000000);
    n = sends;
    fire('0, 1'h1);
    fire('0, 1'h1);
    chk("always", n + 2, sends);
    chk("status", '0, st);
    results;
  end
endmodule
